//--- design/ptc_pkg.sv
/*
 * Shared constants for the paired timer block: register offsets, control
 * word field positions, writable masks, reset values and prescale codes.
 * Assumes a 16-bit register port with one-cycle read latency.
 */
package ptc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register offsets (word addresses on the plain register port)
    localparam logic [3:0] OFF_LOWER_CTRL = 4'h0;
    localparam logic [3:0] OFF_UPPER_CTRL = 4'h1;
    localparam logic [3:0] OFF_LOWER_COUNT = 4'h2;
    localparam logic [3:0] OFF_UPPER_COUNT = 4'h3;
    localparam logic [3:0] OFF_LOWER_PERIOD = 4'h4;
    localparam logic [3:0] OFF_UPPER_PERIOD = 4'h5;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h6;
    localparam logic [3:0] OFF_IRQ_ENABLE = 4'h7;
    localparam logic [3:0] OFF_IRQ_CLEAR = 4'h8;

    // control word field positions
    localparam int BIT_RUN = 15;
    localparam int BIT_HALT_IDLE = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PRESCALE_HI = 5;
    localparam int BIT_PRESCALE_LO = 4;
    localparam int BIT_JOIN = 3;
    localparam int BIT_SOURCE = 1;

    // writable bits; the upper word has no join bit
    localparam logic [15:0] LOWER_CTRL_MASK = 16'ha07a;
    localparam logic [15:0] UPPER_CTRL_MASK = 16'ha072;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;

    // interrupt status bits
    localparam int IRQ_LOWER = 0;
    localparam int IRQ_UPPER = 1;
    localparam logic [15:0] IRQ_MASK = 16'h0003;

    // prescale codes and tick counts (minus one)
    localparam logic [1:0] PS_1 = 2'h0;
    localparam logic [1:0] PS_8 = 2'h1;
    localparam logic [1:0] PS_64 = 2'h2;
    localparam logic [1:0] PS_256 = 2'h3;
    localparam logic [7:0] PS_1_LAST = 8'h00;
    localparam logic [7:0] PS_8_LAST = 8'h07;
    localparam logic [7:0] PS_64_LAST = 8'h3f;
    localparam logic [7:0] PS_256_LAST = 8'hff;

endpackage : ptc_pkg

//--- design/ptc_prescaler.sv
/*
 * One timer's count-source selection, gate and prescaler. Emits a one-cycle
 * count tick. Assumes pin inputs are already synchronous to i_clock.
 */
`timescale 1ns/100ps
module ptc_prescaler
    import ptc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_run,
    input wire logic i_halt,
    input wire logic i_source_ext,
    input wire logic i_gate_en,
    input wire logic [1:0] i_prescale_select,
    input wire logic i_ext_clock,
    input wire logic i_gate,
    output logic o_tick
);
    logic ext_prev_reg;
    logic [7:0] div_reg;
    logic [7:0] div_last;
    logic raw;
    logic ext_rise;

    always_comb begin
        case (i_prescale_select)
            PS_1: div_last = PS_1_LAST;
            PS_8: div_last = PS_8_LAST;
            PS_64: div_last = PS_64_LAST;
            default: div_last = PS_256_LAST;
        endcase
    end

    assign ext_rise = i_ext_clock & ~ext_prev_reg;

    always_comb begin
        if (i_source_ext) begin
            // gate enable has no say on the external source
            raw = ext_rise;
        end else if (i_gate_en) begin
            raw = i_gate;
        end else begin
            raw = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_prev_reg <= 1'b0;
        end else if (i_enable) begin
            ext_prev_reg <= i_ext_clock;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            div_reg <= 8'h00;
            o_tick <= 1'b0;
        end else if (i_enable) begin
            o_tick <= 1'b0;
            if (!i_run) begin
                div_reg <= 8'h00;
            end else if (i_halt) begin
                div_reg <= div_reg;
            end else if (raw) begin
                if (div_reg >= div_last) begin
                    div_reg <= 8'h00;
                    o_tick <= 1'b1;
                end else begin
                    div_reg <= div_reg + 8'h01;
                end
            end
        end
    end
endmodule : ptc_prescaler

//--- design/ptc_timer_pair.sv
/*
 * Paired 16-bit timers, joinable into one 32-bit timer, with control,
 * count and period registers and a sticky period-match interrupt.
 * Assumes a register master with one-cycle strobes, read data next cycle,
 * and pins synchronous to i_clock.
 */
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Contract
// - halt-in-idle bit 13 stops counting in idle
// - external source ignores gate enable
// - internal source: bit 6 enables gating
// - join bit chains timers into 32 bits
// - join bit only in lower control bit 3
// - prescale field 5:4 selects 1,8,64,256
// - run bit 15; lower controls joined pair
// - lower is low word when joined
// - upper controls ignored when joined
module ptc_timer_pair
    import ptc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_idle,
    input wire logic i_lower_ext_clock_pin,
    input wire logic i_upper_ext_clock_pin,
    input wire logic i_lower_gate,
    input wire logic i_upper_gate,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_irq,
    output logic o_lower_match,
    output logic o_upper_match
);
    // counts share the register port, so the width is fixed to it
    if (WIDTH != DATA_W) begin : g_width_check
        $error("ptc_timer_pair: WIDTH must equal the register width");
    end

    logic [15:0] lower_timer_control_reg;
    logic [15:0] upper_timer_control_reg;
    logic [WIDTH-1:0] lower_count_reg;
    logic [WIDTH-1:0] upper_count_reg;
    logic [WIDTH-1:0] lower_period_reg;
    logic [WIDTH-1:0] upper_period_reg;
    logic [15:0] irq_status_reg;
    logic [15:0] irq_enable_reg;
    logic [15:0] rdata_next;

    logic join_wide_mode;
    logic lower_run, upper_run;
    logic lower_halt, upper_halt;
    logic lower_tick, upper_tick;
    logic lower_hit, upper_hit, wide_hit;
    logic lower_event, upper_event;
    logic [15:0] irq_set;
    logic [15:0] irq_clr;
    logic [15:0] uc_eff;

    assign join_wide_mode = lower_timer_control_reg[BIT_JOIN];
    // when joined the upper control word is not consulted at all
    assign uc_eff = join_wide_mode ? 16'h0000
                                   : upper_timer_control_reg;

    assign lower_run = lower_timer_control_reg[BIT_RUN];
    assign upper_run = uc_eff[BIT_RUN];
    assign lower_halt = i_idle
                        & lower_timer_control_reg[BIT_HALT_IDLE];
    assign upper_halt = i_idle & uc_eff[BIT_HALT_IDLE];

    ptc_prescaler u_lower_ps (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_enable(i_enable),
        .i_run(lower_run),
        .i_halt(lower_halt),
        .i_source_ext(lower_timer_control_reg[BIT_SOURCE]),
        .i_gate_en(lower_timer_control_reg[BIT_GATE]),
        .i_prescale_select(lower_timer_control_reg[BIT_PRESCALE_HI:
                                                   BIT_PRESCALE_LO]),
        .i_ext_clock(i_lower_ext_clock_pin),
        .i_gate(i_lower_gate),
        .o_tick(lower_tick)
    );

    ptc_prescaler u_upper_ps (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_enable(i_enable),
        .i_run(upper_run),
        .i_halt(upper_halt),
        .i_source_ext(uc_eff[BIT_SOURCE]),
        .i_gate_en(uc_eff[BIT_GATE]),
        .i_prescale_select(uc_eff[BIT_PRESCALE_HI:BIT_PRESCALE_LO]),
        .i_ext_clock(i_upper_ext_clock_pin),
        .i_gate(i_upper_gate),
        .o_tick(upper_tick)
    );

    assign lower_hit = lower_count_reg == lower_period_reg;
    assign upper_hit = upper_count_reg == upper_period_reg;
    assign wide_hit = lower_hit & upper_hit;

    assign lower_event = !join_wide_mode && lower_tick && lower_hit;
    assign upper_event = join_wide_mode ? (lower_tick && wide_hit)
                                        : (upper_tick && upper_hit);

    // lower word counts from the lower tick in both modes
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            lower_count_reg <= COUNT_RESET;
        end else if (i_enable) begin
            if (i_write && i_addr == OFF_LOWER_COUNT) begin
                lower_count_reg <= i_wdata;
            end else if (lower_tick) begin
                if (join_wide_mode ? wide_hit : lower_hit) begin
                    lower_count_reg <= COUNT_RESET;
                end else begin
                    lower_count_reg <= lower_count_reg + 16'h0001;
                end
            end
        end
    end

    // joined: the upper word is the carry stage of the lower word
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            upper_count_reg <= COUNT_RESET;
        end else if (i_enable) begin
            if (i_write && i_addr == OFF_UPPER_COUNT) begin
                upper_count_reg <= i_wdata;
            end else if (join_wide_mode) begin
                if (lower_tick && wide_hit) begin
                    upper_count_reg <= COUNT_RESET;
                end else if (lower_tick && lower_count_reg == 16'hffff) begin
                    upper_count_reg <= upper_count_reg + 16'h0001;
                end
            end else if (upper_tick) begin
                if (upper_hit) begin
                    upper_count_reg <= COUNT_RESET;
                end else begin
                    upper_count_reg <= upper_count_reg + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            lower_timer_control_reg <= CTRL_RESET;
            upper_timer_control_reg <= CTRL_RESET;
            lower_period_reg <= PERIOD_RESET;
            upper_period_reg <= PERIOD_RESET;
            irq_enable_reg <= 16'h0000;
        end else if (i_enable && i_write) begin
            if (i_addr == OFF_LOWER_CTRL) begin
                lower_timer_control_reg <= i_wdata & LOWER_CTRL_MASK;
            end else if (i_addr == OFF_UPPER_CTRL) begin
                // bit 3 stays unimplemented here
                upper_timer_control_reg <= i_wdata & UPPER_CTRL_MASK;
            end else if (i_addr == OFF_LOWER_PERIOD) begin
                lower_period_reg <= i_wdata;
            end else if (i_addr == OFF_UPPER_PERIOD) begin
                upper_period_reg <= i_wdata;
            end else if (i_addr == OFF_IRQ_ENABLE) begin
                irq_enable_reg <= i_wdata & IRQ_MASK;
            end
        end
    end

    always_comb begin
        irq_set = 16'h0000;
        irq_set[IRQ_LOWER] = lower_event;
        irq_set[IRQ_UPPER] = upper_event;
        irq_clr = (i_write && i_addr == OFF_IRQ_CLEAR) ? i_wdata : 16'h0000;
    end

    // a match in the clearing cycle survives the clear
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_status_reg <= 16'h0000;
        end else if (i_enable) begin
            irq_status_reg <= ((irq_status_reg & ~irq_clr) | irq_set)
                              & IRQ_MASK;
        end
    end

    always_comb begin
        if (i_addr == OFF_LOWER_CTRL) begin
            rdata_next = lower_timer_control_reg;
        end else if (i_addr == OFF_UPPER_CTRL) begin
            rdata_next = upper_timer_control_reg;
        end else if (i_addr == OFF_LOWER_COUNT) begin
            rdata_next = lower_count_reg;
        end else if (i_addr == OFF_UPPER_COUNT) begin
            rdata_next = upper_count_reg;
        end else if (i_addr == OFF_LOWER_PERIOD) begin
            rdata_next = lower_period_reg;
        end else if (i_addr == OFF_UPPER_PERIOD) begin
            rdata_next = upper_period_reg;
        end else if (i_addr == OFF_IRQ_STATUS) begin
            rdata_next = irq_status_reg;
        end else if (i_addr == OFF_IRQ_ENABLE) begin
            rdata_next = irq_enable_reg;
        end else begin
            rdata_next = 16'h0000;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 16'h0000;
        end else if (i_enable) begin
            o_rdata <= i_read ? rdata_next : 16'h0000;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
            o_lower_match <= 1'b0;
            o_upper_match <= 1'b0;
        end else if (i_enable) begin
            o_irq <= |((((irq_status_reg & ~irq_clr) | irq_set) & IRQ_MASK)
                       & irq_enable_reg);
            o_lower_match <= lower_event;
            o_upper_match <= upper_event;
        end
    end
endmodule : ptc_timer_pair

//--- sim/ptc_timer_pair_monitor.sv
/* Port checker for ptc_timer_pair, bound to each instance.
   Assumes one clock domain and a strobe register port. */
`timescale 1ns/100ps
module ptc_timer_pair_monitor
    import ptc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_idle,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic o_irq,
    input wire logic o_lower_match,
    input wire logic o_upper_match
);
    logic run_seen, halt_seen, join_seen, ien_seen;
    logic wr_ok;
    assign wr_ok = i_write && i_enable;
    // mirrors of control bits, since they are not visible at the ports
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            run_seen <= 1'b0;
            halt_seen <= 1'b0;
            join_seen <= 1'b0;
        end else if (wr_ok && i_addr == OFF_LOWER_CTRL) begin
            run_seen <= i_wdata[BIT_RUN];
            halt_seen <= i_wdata[BIT_HALT_IDLE];
            join_seen <= i_wdata[BIT_JOIN];
        end
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ien_seen <= 1'b0;
        end else if (wr_ok && i_addr == OFF_IRQ_ENABLE) begin
            ien_seen <= i_wdata[IRQ_UPPER];
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    property p_rdata_idle;
        $past(i_enable) && !$past(i_read) |-> o_rdata == '0;
    endproperty
    property p_lower_mask;
        i_read && i_enable && i_addr == OFF_LOWER_CTRL
            |=> (o_rdata & ~LOWER_CTRL_MASK) == '0;
    endproperty
    property p_upper_join;
        i_read && i_enable && i_addr == OFF_UPPER_CTRL |=> !o_rdata[BIT_JOIN];
    endproperty
    property p_unmapped;
        i_read && i_enable && i_addr > OFF_IRQ_CLEAR |=> o_rdata == '0;
    endproperty
    property p_ien_off;
        (wr_ok && i_addr == OFF_IRQ_ENABLE && i_wdata == '0) ##1 i_enable
            |=> !o_irq;
    endproperty
    property p_join_lower;
        join_seen && $past(join_seen) |-> !o_lower_match;
    endproperty
    property p_idle_halt;
        (halt_seen && i_idle && i_enable) [*4] |-> !o_lower_match;
    endproperty
    property p_stopped;
        (!run_seen && i_enable) [*4] |-> !o_lower_match;
    endproperty
    property p_upper_irq;
        (o_upper_match && ien_seen && !i_write) ##1 i_enable |-> o_irq;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not 0");
    a_lower_mask: assert property (p_lower_mask)
        else $error("lower bits");
    a_upper_join: assert property (p_upper_join)
        else $error("upper bit3");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_ien_off: assert property (p_ien_off)
        else $error("irq not masked");
    a_join_lower: assert property (p_join_lower)
        else $error("lower hit");
    a_idle_halt: assert property (p_idle_halt)
        else $error("idle count");
    a_stopped: assert property (p_stopped)
        else $error("stopped count");
    a_upper_irq: assert property (p_upper_irq)
        else $error("no irq");
    c_lower: cover property (o_lower_match);
    c_upper: cover property (o_upper_match);
    c_irq: cover property ($rose(o_irq));
endmodule : ptc_timer_pair_monitor
bind ptc_timer_pair ptc_timer_pair_monitor ptc_timer_pair_monitor_i (
    .i_clock, .i_resetn, .i_enable, .i_idle, .i_addr, .i_wdata, .i_write,
    .i_read, .o_rdata, .o_irq, .o_lower_match, .o_upper_match);

//--- sim/test_ptc_timer_pair.sv
/* Self-checking bench for ptc_timer_pair: registers, prescale, gate,
   source, idle, joined mode, interrupt. Assumes the bound monitor. */
`timescale 1ns/100ps
module test_ptc_timer_pair;
    import ptc_pkg::*;
    logic i_clock = 0, i_resetn = 0, i_enable = 1, i_idle = 0;
    logic i_lower_ext_clock_pin = 0, i_upper_ext_clock_pin = 0;
    logic i_lower_gate = 0, i_upper_gate = 0, i_write = 0, i_read = 0;
    logic ext_run = 0;
    logic [3:0] i_addr = 0;
    logic [15:0] i_wdata = 0, o_rdata;
    logic o_irq, o_lower_match, o_upper_match;
    int fail_count = 0, n_compared = 0;
    ptc_timer_pair ptc_timer_pair_i (.i_clock, .i_resetn, .i_enable,
        .i_idle, .i_lower_ext_clock_pin, .i_upper_ext_clock_pin,
        .i_lower_gate, .i_upper_gate, .i_addr, .i_wdata, .i_write, .i_read,
        .o_rdata, .o_irq, .o_lower_match, .o_upper_match);
    initial forever #25 i_clock = ~i_clock;
    // one rising pin edge every second clock
    always @(posedge i_clock) begin
        if (ext_run) begin
            i_lower_ext_clock_pin <= ~i_lower_ext_clock_pin;
        end
    end
    task automatic end_of_test;
        $display("mismatches %0d compared %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    // count advance over exactly twelve clocks
    task automatic rate(output logic [15:0] n);
        logic [15:0] a, b;
        rd(OFF_LOWER_COUNT, a);
        repeat (10) @(posedge i_clock);
        rd(OFF_LOWER_COUNT, b);
        n = b - a;
    endtask : rate
    task automatic gap(input bit up, output logic [15:0] n);
        n = 0;
        do begin
            @(posedge i_clock);
            #1 n++;
            if (n > 3000) begin
                fail_count++;
                $display("[ERR] match wait expected pulse seen none");
                end_of_test();
            end
        end while ((up ? o_upper_match : o_lower_match) !== 1'b1);
    endtask : gap
    function automatic logic [15:0] rst_val(input logic [3:0] a);
        return (a == OFF_LOWER_PERIOD || a == OFF_UPPER_PERIOD) ?
            PERIOD_RESET : 16'h0000;
    endfunction : rst_val
    function automatic logic [15:0] keep(input logic [3:0] a);
        return a == OFF_LOWER_CTRL ? LOWER_CTRL_MASK :
            a == OFF_UPPER_CTRL ? UPPER_CTRL_MASK : 16'h0000;
    endfunction : keep
    initial begin
        logic [15:0] v, p, n;
        logic [3:0] wl[6] = '{4'h0, 4'h1, 4'h6, 4'h8, 4'h9, 4'hf};
        logic [15:0] ps_n[4] = '{16'h0001, 16'h0008, 16'h0040, 16'h0100};
        void'($urandom(32'h345292ff));
        repeat (16) @(posedge i_clock);
        i_resetn <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], v);
            chk("reset value", rst_val(a[3:0]), v);
        end
        foreach (wl[k]) begin
            p = 16'($urandom);
            wr(wl[k], p);
            rd(wl[k], v);
            chk("write mask", p & keep(wl[k]), v);
        end
        wr(OFF_LOWER_CTRL, 16'h0000);
        wr(OFF_UPPER_CTRL, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            // stop first so no match of the old setting spoils the gap
            wr(OFF_LOWER_CTRL, 16'h0000);
            p = 16'($urandom_range(7, 1));
            wr(OFF_LOWER_PERIOD, p);
            wr(OFF_LOWER_COUNT, 16'h0000);
            wr(OFF_LOWER_CTRL, 16'h8000 | 16'(c << 4));
            gap(0, n);
            gap(0, n);
            chk("match gap", (p + 1) * ps_n[c], n);
        end
        wr(OFF_LOWER_CTRL, 16'h0000);
        rd(OFF_IRQ_STATUS, v);
        chk("status", 16'h0001, v);
        wr(OFF_UPPER_COUNT, 16'h0000);
        wr(OFF_UPPER_PERIOD, 16'h0004);
        wr(OFF_UPPER_CTRL, 16'h8010);
        gap(1, n);
        gap(1, n);
        chk("upper gap", 16'h0028, n);
        wr(OFF_UPPER_CTRL, 16'h0000);
        wr(OFF_IRQ_CLEAR, 16'h0003);
        wr(OFF_LOWER_PERIOD, 16'hffff);
        wr(OFF_LOWER_CTRL, 16'h8040);
        rate(n);
        chk("gated low", 16'h0000, n);
        @(posedge i_clock) i_lower_gate <= 1'b1;
        rate(n);
        chk("gated high", 16'h000c, n);
        @(posedge i_clock) i_lower_gate <= 1'b0;
        wr(OFF_LOWER_CTRL, 16'h8000);
        rate(n);
        chk("ungated", 16'h000c, n);
        // ten disabled edges between reads leave three live increments
        rd(OFF_LOWER_COUNT, p);
        @(posedge i_clock) i_enable <= 1'b0;
        repeat (10) @(posedge i_clock);
        i_enable <= 1'b1;
        rd(OFF_LOWER_COUNT, v);
        chk("enable low", 16'h0003, v - p);
        wr(OFF_LOWER_CTRL, 16'h8042);
        ext_run <= 1'b1;
        rate(n);
        chk("pin edges", 16'h0006, n);
        ext_run <= 1'b0;
        wr(OFF_LOWER_CTRL, 16'ha000);
        i_idle <= 1'b1;
        rate(n);
        chk("idle halted", 16'h0000, n);
        wr(OFF_LOWER_CTRL, 16'h8000);
        rate(n);
        chk("idle running", 16'h000c, n);
        // stop the lower word so the preset counts stay put
        wr(OFF_LOWER_CTRL, 16'h0000);
        // upper halts in idle unless its control is ignored
        wr(OFF_UPPER_CTRL, 16'ha000);
        wr(OFF_UPPER_PERIOD, 16'hffff);
        wr(OFF_LOWER_COUNT, 16'hffff);
        wr(OFF_UPPER_COUNT, 16'h0000);
        wr(OFF_LOWER_CTRL, 16'h8008);
        wr(OFF_LOWER_CTRL, 16'h0008);
        rd(OFF_UPPER_COUNT, v);
        chk("carry", 16'h0001, v);
        wr(OFF_LOWER_PERIOD, 16'h0001);
        wr(OFF_UPPER_PERIOD, 16'h0001);
        wr(OFF_LOWER_COUNT, 16'hffff);
        wr(OFF_UPPER_COUNT, 16'h0000);
        wr(OFF_IRQ_CLEAR, 16'h0003);
        wr(OFF_IRQ_ENABLE, 16'h0002);
        wr(OFF_LOWER_CTRL, 16'h8008);
        gap(1, n);
        wr(OFF_LOWER_CTRL, 16'h0008);
        rd(OFF_IRQ_STATUS, v);
        chk("joined status", 16'h0002, v);
        chk("irq on", 16'h0001, {15'h0, o_irq});
        // the irq level follows an enable write one cycle late
        wr(OFF_IRQ_ENABLE, 16'h0000);
        @(posedge i_clock);
        #1 chk("irq masked", 16'h0000, {15'h0, o_irq});
        wr(OFF_IRQ_ENABLE, 16'h0002);
        @(posedge i_clock);
        #1 chk("irq again", 16'h0001, {15'h0, o_irq});
        wr(OFF_IRQ_CLEAR, 16'h0002);
        #1 chk("irq cleared", 16'h0000, {15'h0, o_irq});
        rd(OFF_IRQ_STATUS, v);
        chk("status clear", 16'h0000, v);
        end_of_test();
    end
endmodule : test_ptc_timer_pair
